/* hw/qfb_pkg.sv */
// Constants for the queue and bit-framing register block.
// Assumes APB with 32-bit data and 8-bit byte addresses.
package qfb_pkg;
  // ----------------------------------------
  // Queue geometry
  // ----------------------------------------
  localparam int unsigned QDEPTH = 64;
  localparam logic [6:0] QFULL = 7'h40;
  localparam logic [3:0] ID_BYTES = 4'hA;
  // ----------------------------------------
  // Register indices (byte address = 4 x index)
  // ----------------------------------------
  localparam logic [5:0] IDX_DATA = 6'h09;
  localparam logic [5:0] IDX_LEVEL = 6'h0A;
  localparam logic [5:0] IDX_THR = 6'h0B;
  localparam logic [5:0] IDX_CTRL = 6'h0C;
  localparam logic [5:0] IDX_FRAME = 6'h0D;
  localparam logic [5:0] IDX_STAT = 6'h07;
  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int unsigned B_FLUSH = 7;
  localparam int unsigned B_TSTOP = 7;
  localparam int unsigned B_TSTART = 6;
  localparam int unsigned B_IDCOPY = 5;
  localparam int unsigned B_INIT = 4;
  localparam int unsigned B_SEND = 7;
  localparam int unsigned B_ALIGN = 4;
  localparam int unsigned B_ST_HI = 0;
  localparam int unsigned B_ST_LO = 1;
  localparam int unsigned B_ST_OVF = 2;
  localparam int unsigned B_ST_MODEM = 4;
  // ----------------------------------------
  // Reset values and modem codes
  // ----------------------------------------
  localparam logic [5:0] THR_RST = 6'h08;
  localparam logic [2:0] ALIGN_RST = 3'h0;
  localparam logic [2:0] TXBITS_RST = 3'h0;
  localparam logic [2:0] MODEM_WAIT_SEND = 3'h1;
endpackage : qfb_pkg

/* hw/qfb_regs.sv */
// Queue, fill level, threshold, misc control and bit-framing registers.
// Assumes an APB master on REF_CLK and a transceiver core beside it.
`timescale 1ns/100ps
// Behaviour
// [R01] 64-byte queue; data-port write pushes, data-port read pops oldest byte.
// [R02] Queue stages bytes between host and the core's serial streams.
// [R03] Writing one to flush bit resets pointers and clears overflow error.
// [R04] Flush, timer stop and timer start act on one, read as zero.
// [R05] Read-only 7-bit fill count, up on push, down on pop.
// [R06] 6-bit warning threshold, resets to 08h, bits 7..6 read zero.
// [R07] High alert set when free space is at most the threshold.
// [R08] Low alert set when bytes held are at most the threshold.
// [R09] Writing one to control bit 7 stops the timer at once.
// [R10] Writing one to control bit 6 starts the timer at once.
// [R11] Identifier copy bit loads 10 stored bytes into queue, then self-clears.
// [R12] Role bit: one selects initiator, zero selects target.
// [R13] Read-only bits 2..0 show valid bits of last received byte.
// [R14] Send-start begins transmission only while exchange command is active.
// [R15] Receive alignment bits 6..4 give first stored bit position.
// [R16] Host keeps receive alignment zero outside 106 kbit/s anticollision.
// [R17] Transmit bits 2..0 give bits of final byte sent; zero sends eight.
// [R18] Modem state reads 001 while exchange waits for send-start.
// [R19] Data write when full sets overflow, drops byte, count unchanged.
// [R20] Data read when empty returns undefined byte, count stays zero.
module qfb_regs (
  input wire logic REF_CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic CORE_PUSH_VALID,
  input wire logic [7:0] CORE_PUSH_DATA,
  output logic CORE_PUSH_READY,
  input wire logic CORE_POP_REQ,
  output logic CORE_POP_READY,
  output logic [7:0] CORE_POP_DATA,
  input wire logic [2:0] CORE_RX_LAST_BITS,
  input wire logic EXCHANGE_ACTIVE,
  input wire logic [2:0] MODEM_STATE_IN,
  input wire logic [79:0] STORED_ID,
  output logic TIMER_START,
  output logic TIMER_STOP,
  output logic SEND_START,
  output logic INITIATOR,
  output logic [2:0] RX_ALIGN,
  output logic [2:0] TX_LAST_BITS,
  output logic HIGH_ALERT,
  output logic LOW_ALERT,
  output logic OVERFLOW_ERR,
  output logic [2:0] MODEM_STATE
);
  import qfb_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [7:0] mem [QDEPTH];
  logic [5:0] wr_ptr;
  logic [5:0] rd_ptr;
  logic [6:0] count;
  logic [5:0] threshold;
  logic copy_busy;
  logic [3:0] copy_idx;
  logic send_done;
  logic pready_q;

  // ----------------------------------------
  // APB decode
  // ----------------------------------------
  logic [5:0] idx;
  logic a_data;
  logic hit;
  logic stall;
  logic bus_done;
  logic bus_wr;
  logic [7:0] wbyte;
  logic [7:0] rbyte;

  assign idx = PADDR[7:2];
  assign a_data = (idx == IDX_DATA) && (PADDR[1:0] == 2'h0);
  assign hit = (PADDR[1:0] == 2'h0) && ((idx == IDX_DATA) || (idx == IDX_LEVEL) ||
    (idx == IDX_THR) || (idx == IDX_CTRL) || (idx == IDX_FRAME) || (idx == IDX_STAT));
  // Host data write waits while the identifier copy owns the push side
  assign stall = a_data && PWRITE && copy_busy;
  assign bus_done = PSEL && PENABLE && pready_q;
  assign bus_wr = bus_done && PWRITE && hit;
  assign wbyte = PWDATA[7:0];
  assign PREADY = pready_q;

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      pready_q <= 1'b0;
    end else if (bus_done) begin
      pready_q <= 1'b0;
    end else if (PSEL && PENABLE && !stall) begin
      pready_q <= 1'b1;
    end
  end

  // ----------------------------------------
  // Queue push/pop arbitration
  // ----------------------------------------
  logic full;
  logic empty;
  logic flush;
  logic apb_push;
  logic apb_pop;
  logic core_push;
  logic core_pop;
  logic push;
  logic [7:0] push_data;
  logic do_push;
  logic do_pop;
  logic [6:0] next_count;

  assign full = (count == QFULL);
  assign empty = (count == 7'h00);
  assign flush = bus_wr && (idx == IDX_LEVEL) && wbyte[B_FLUSH]; // R03
  assign apb_push = bus_wr && a_data; // R01
  assign apb_pop = bus_done && !PWRITE && a_data; // R01
  // Core pushes are held off during host writes to the data or level register, and core pops
  // during host data reads, so a captured read byte is still the head when the pop lands
  assign CORE_PUSH_READY = !copy_busy &&
    !(PSEL && PWRITE && (a_data || idx == IDX_LEVEL)); // R02
  assign CORE_POP_READY = !empty && !(PSEL && !PWRITE && a_data); // R02
  assign core_push = CORE_PUSH_VALID && CORE_PUSH_READY;
  assign core_pop = CORE_POP_REQ && CORE_POP_READY;
  assign CORE_POP_DATA = mem[rd_ptr];
  assign push = apb_push || copy_busy || core_push;

  always_comb begin
    if (apb_push) begin
      push_data = wbyte;
    end else if (copy_busy) begin
      push_data = STORED_ID[8 * copy_idx +: 8]; // R11
    end else begin
      push_data = CORE_PUSH_DATA;
    end
  end

  assign do_push = push && !full && !flush; // R19
  assign do_pop = (apb_pop || core_pop) && !empty && !flush; // R20

  always_comb begin
    if (flush) begin
      next_count = 7'h00; // R03
    end else begin
      next_count = count + {6'h00, do_push} - {6'h00, do_pop}; // R05
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      wr_ptr <= 6'h00;
      rd_ptr <= 6'h00;
      count <= 7'h00;
    end else begin
      count <= next_count;
      if (flush) begin
        wr_ptr <= 6'h00; // R03
        rd_ptr <= 6'h00;
      end else begin
        if (do_push) begin
          wr_ptr <= wr_ptr + 6'h01;
        end
        if (do_pop) begin
          rd_ptr <= rd_ptr + 6'h01;
        end
      end
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (do_push) begin
      mem[wr_ptr] <= push_data;
    end
  end

  // Overflow: a rejected push wins over a flush in the same cycle
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      OVERFLOW_ERR <= 1'b0;
    end else if (push && full) begin
      OVERFLOW_ERR <= 1'b1; // R19
    end else if (flush) begin
      OVERFLOW_ERR <= 1'b0; // R03
    end
  end

  // ----------------------------------------
  // Threshold and alerts
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      threshold <= THR_RST; // R06
    end else if (bus_wr && idx == IDX_THR) begin
      threshold <= wbyte[5:0];
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      HIGH_ALERT <= 1'b0;
      LOW_ALERT <= 1'b1;
    end else begin
      HIGH_ALERT <= (QFULL - count) <= {1'b0, threshold}; // R07
      LOW_ALERT <= count <= {1'b0, threshold}; // R08
    end
  end

  // ----------------------------------------
  // Misc control
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      TIMER_STOP <= 1'b0;
      TIMER_START <= 1'b0;
    end else begin
      TIMER_STOP <= bus_wr && idx == IDX_CTRL && wbyte[B_TSTOP]; // R09
      TIMER_START <= bus_wr && idx == IDX_CTRL && wbyte[B_TSTART]; // R10
    end
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      INITIATOR <= 1'b0;
    end else if (bus_wr && idx == IDX_CTRL) begin
      INITIATOR <= wbyte[B_INIT]; // R12
    end
  end

  // Identifier copy: one byte per cycle, lowest byte first; flush aborts
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      copy_busy <= 1'b0;
      copy_idx <= 4'h0;
    end else if (flush) begin
      copy_busy <= 1'b0;
      copy_idx <= 4'h0;
    end else if (copy_busy) begin
      if (copy_idx == ID_BYTES - 4'h1) begin
        copy_busy <= 1'b0; // R11
        copy_idx <= 4'h0;
      end else begin
        copy_idx <= copy_idx + 4'h1;
      end
    end else if (bus_wr && idx == IDX_CTRL && wbyte[B_IDCOPY]) begin
      copy_busy <= 1'b1; // R11
    end
  end

  // ----------------------------------------
  // Bit framing
  // ----------------------------------------
  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      RX_ALIGN <= ALIGN_RST;
      TX_LAST_BITS <= TXBITS_RST;
    end else if (bus_wr && idx == IDX_FRAME) begin
      RX_ALIGN <= wbyte[B_ALIGN +: 3]; // R15
      TX_LAST_BITS <= wbyte[2:0]; // R17
    end
  end

  logic send_req;
  assign send_req = bus_wr && idx == IDX_FRAME && wbyte[B_SEND];

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      SEND_START <= 1'b0;
      send_done <= 1'b0;
    end else begin
      SEND_START <= send_req && EXCHANGE_ACTIVE; // R14
      if (!EXCHANGE_ACTIVE) begin
        send_done <= 1'b0;
      end else if (send_req) begin
        send_done <= 1'b1;
      end
    end
  end

  always_comb begin
    if (EXCHANGE_ACTIVE && !send_done) begin
      MODEM_STATE = MODEM_WAIT_SEND; // R18
    end else begin
      MODEM_STATE = MODEM_STATE_IN;
    end
  end

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always_comb begin
    case (idx)
      IDX_DATA: rbyte = mem[rd_ptr]; // R20
      IDX_LEVEL: rbyte = {1'b0, count}; // R04 R05
      IDX_THR: rbyte = {2'h0, threshold}; // R06
      IDX_CTRL: rbyte = {2'h0, copy_busy, INITIATOR, 1'b0, CORE_RX_LAST_BITS}; // R04 R13
      IDX_FRAME: rbyte = {1'b0, RX_ALIGN, 1'b0, TX_LAST_BITS}; // R04
      IDX_STAT: rbyte = {1'b0, MODEM_STATE, 1'b0, OVERFLOW_ERR, LOW_ALERT, HIGH_ALERT};
      default: rbyte = 8'h00;
    endcase
  end

  always_ff @(posedge REF_CLK) begin
    if (!RESETN) begin
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else if (PSEL && PENABLE && !pready_q && !stall) begin
      PRDATA <= (hit && !PWRITE) ? {24'h00_0000, rbyte} : 32'h0000_0000;
      PSLVERR <= !hit;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_FLUSH: assert property (@(posedge REF_CLK) disable iff (!RESETN) // R03
    flush |=> count == 7'h00 && wr_ptr == rd_ptr)
    else $error("flush did not empty queue");
  AST_FILL_UP: assert property (@(posedge REF_CLK) disable iff (!RESETN) // R05
    apb_push && !full && !flush && !do_pop |=> count == $past(count) + 7'h01)
    else $error("fill count did not rise on data write");
  AST_THR_RST: assert property (@(posedge REF_CLK) // R06
    !RESETN |=> threshold == THR_RST)
    else $error("threshold reset value wrong");
  AST_HIGH: assert property (@(posedge REF_CLK) disable iff (!RESETN) // R07
    ##1 HIGH_ALERT == ((QFULL - $past(count)) <= {1'b0, $past(threshold)}))
    else $error("high alert mismatch");
  AST_LOW: assert property (@(posedge REF_CLK) disable iff (!RESETN) // R08
    ##1 LOW_ALERT == ($past(count) <= {1'b0, $past(threshold)}))
    else $error("low alert mismatch");
  AST_TSTOP: assert property (@(posedge REF_CLK) disable iff (!RESETN) // R09
    bus_wr && idx == IDX_CTRL && wbyte[B_TSTOP] |=> TIMER_STOP ##1 !TIMER_STOP)
    else $error("timer stop pulse wrong");
  AST_TSTART: assert property (@(posedge REF_CLK) disable iff (!RESETN) // R10
    $rose(TIMER_START) |-> $past(bus_wr) && $past(wbyte[B_TSTART]))
    else $error("timer start without write");
  AST_COPY: assert property (@(posedge REF_CLK) disable iff (!RESETN) // R11
    $rose(copy_busy) && !flush |-> copy_busy [*8] ##1 copy_busy ##1 copy_busy ##1 !copy_busy)
    else $error("identifier copy length wrong");
  AST_SEND: assert property (@(posedge REF_CLK) disable iff (!RESETN) // R14
    SEND_START |-> $past(EXCHANGE_ACTIVE) && $past(send_req))
    else $error("send start outside exchange");
  AST_MODEM: assert property (@(posedge REF_CLK) disable iff (!RESETN) // R18
    EXCHANGE_ACTIVE && !send_done |-> MODEM_STATE == MODEM_WAIT_SEND)
    else $error("modem state not waiting");
  AST_OVF: assert property (@(posedge REF_CLK) disable iff (!RESETN) // R19
    apb_push && full && !do_pop |=> OVERFLOW_ERR && count == QFULL)
    else $error("overflow not flagged");
  AST_EMPTY: assert property (@(posedge REF_CLK) disable iff (!RESETN) // R20
    apb_pop && empty && !push |=> count == 7'h00)
    else $error("empty read changed count");
  AST_POP: assert property (@(posedge REF_CLK) disable iff (!RESETN) // R01
    apb_pop && !empty && !push |=> count == $past(count) - 7'h01)
    else $error("fill count did not fall on data read");
  AST_RO_LEVEL: assert property (@(posedge REF_CLK) disable iff (!RESETN) // R04
    bus_done && !PWRITE && idx == IDX_LEVEL |-> !PRDATA[B_FLUSH])
    else $error("flush bit did not read as zero");
  AST_INIT: assert property (@(posedge REF_CLK) disable iff (!RESETN) // R12
    bus_wr && idx == IDX_CTRL |=> INITIATOR == $past(wbyte[B_INIT]))
    else $error("role bit not written");
  AST_FRAME: assert property (@(posedge REF_CLK) disable iff (!RESETN) // R15 R17
    bus_wr && idx == IDX_FRAME |=> RX_ALIGN == $past(wbyte[6:4]) && TX_LAST_BITS == $past(wbyte[2:0]))
    else $error("framing fields not written");
  AST_SEND_IDLE: assert property (@(posedge REF_CLK) disable iff (!RESETN) // R14
    send_req && !EXCHANGE_ACTIVE |=> !SEND_START)
    else $error("send start outside exchange");
endmodule : qfb_regs

/* tb/qfb_host.sv */
// APB host model that reaches the queue and framing registers.
// Assumes each task is entered just after a rising ref_clk edge.
`timescale 1ns/100ps
module qfb_host (
  input wire logic ref_clk,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // Setup, access held until pready, then release and idle one cycle.
  // Callers keep receive alignment at zero except t_frame, which writes 5 and then clears it.
  task automatic xfer(input logic wr, input logic [5:0] idx, input logic [7:0] wd,
                      output logic [31:0] rd, output logic err);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, wd};
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge ref_clk);
  endtask : xfer
endmodule : qfb_host

/* tb/test_fifo_and_bit_framing_regs.sv */
// Self-checking bench for the queue and bit-framing register block.
// Assumes the design answers APB within a few cycles.
`timescale 1ns/100ps
module test_fifo_and_bit_framing_regs;
  import qfb_pkg::*;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic push_valid = 1'b0, pop_req = 1'b0, exch = 1'b0;
  logic push_ready, pop_ready, t_start, t_stop, send_start, initiator, hi, lo, ovf;
  logic [7:0] push_data = 8'h00, pop_data;
  logic [2:0] rx_last = 3'h5, modem_in = 3'h6, rx_align, tx_bits, modem;
  logic [79:0] stored_id = 80'h0A090807060504030201;
  int n_mismatch = 0, checks = 0, n_start = 0, n_stop = 0, n_send = 0;

  always #20 ref_clk = ~ref_clk;

  qfb_host host (.ref_clk(ref_clk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

  qfb_regs uut (.REF_CLK(ref_clk), .RESETN(resetn), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
    .PSLVERR(pslverr), .CORE_PUSH_VALID(push_valid), .CORE_PUSH_DATA(push_data),
    .CORE_PUSH_READY(push_ready), .CORE_POP_REQ(pop_req), .CORE_POP_READY(pop_ready),
    .CORE_POP_DATA(pop_data), .CORE_RX_LAST_BITS(rx_last), .EXCHANGE_ACTIVE(exch),
    .MODEM_STATE_IN(modem_in), .STORED_ID(stored_id), .TIMER_START(t_start),
    .TIMER_STOP(t_stop), .SEND_START(send_start), .INITIATOR(initiator),
    .RX_ALIGN(rx_align), .TX_LAST_BITS(tx_bits), .HIGH_ALERT(hi), .LOW_ALERT(lo),
    .OVERFLOW_ERR(ovf), .MODEM_STATE(modem));

  // Pulse counters for the strobe outputs
  always @(posedge ref_clk) begin
    if (t_start === 1'b1) n_start++;
    if (t_stop === 1'b1) n_stop++;
    if (send_start === 1'b1) n_send++;
  end
  // ----------------------------------------
  // Checks and bus helpers
  // ----------------------------------------
  task automatic complete_run;
    $display("Comparisons %0d, mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : complete_run

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic e;
    host.xfer(1'b1, idx, d, r, e);
  endtask : wr

  task automatic rd_chk(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    host.xfer(1'b0, idx, 8'h00, r, e);
    cmp(r, exp);
  endtask : rd_chk
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    logic [31:0] r;
    logic e;
    rd_chk(IDX_LEVEL, 32'h0);
    rd_chk(IDX_THR, 32'h8);
    rd_chk(IDX_CTRL, 32'h5);
    rd_chk(IDX_FRAME, 32'h0);
    cmp({30'h0, hi, lo}, 32'h1);
    host.xfer(1'b0, 6'h3F, 8'h00, r, e);
    cmp({31'h0, e}, 32'h1);
    wr(IDX_THR, 8'hFF);
    rd_chk(IDX_THR, 32'h3F);
    wr(IDX_THR, 8'h08);
  endtask : t_reset

  task automatic t_queue;
    logic [31:0] r;
    logic e;
    for (int i = 1; i < 4; i++) wr(IDX_DATA, 8'(i * 17));
    rd_chk(IDX_LEVEL, 32'h3);
    for (int i = 1; i < 4; i++) rd_chk(IDX_DATA, 32'(i * 17));
    host.xfer(1'b0, IDX_DATA, 8'h00, r, e);
    cmp({31'h0, e}, 32'h0);
    rd_chk(IDX_LEVEL, 32'h0);
  endtask : t_queue

  task automatic t_fill;
    for (int i = 1; i <= 64; i++) begin
      wr(IDX_DATA, 8'(i));
      @(posedge ref_clk);
      if (i inside {8, 9, 55, 56}) cmp({30'h0, hi, lo}, {30'h0, i >= 56, i <= 8});
    end
    wr(IDX_DATA, 8'hEE);
    cmp({31'h0, ovf}, 32'h1);
    rd_chk(IDX_LEVEL, 32'h40);
    rd_chk(IDX_DATA, 32'h1);
    wr(IDX_LEVEL, 8'h80);
    rd_chk(IDX_LEVEL, 32'h0);
    cmp({31'h0, ovf}, 32'h0);
  endtask : t_fill

  task automatic t_ctrl;
    wr(IDX_CTRL, 8'h80);
    wr(IDX_CTRL, 8'h40);
    repeat (2) @(posedge ref_clk);
    cmp(32'(n_stop), 32'h1);
    cmp(32'(n_start), 32'h1);
    wr(IDX_CTRL, 8'h10);
    cmp({31'h0, initiator}, 32'h1);
    rd_chk(IDX_CTRL, 32'h15);
    wr(IDX_CTRL, 8'h00);
    cmp({31'h0, initiator}, 32'h0);
  endtask : t_ctrl

  task automatic t_frame;
    wr(IDX_FRAME, 8'h80);
    cmp(32'(n_send), 32'h0);
    cmp({29'h0, modem}, 32'h6);
    exch <= 1'b1;
    repeat (2) @(posedge ref_clk);
    cmp({29'h0, modem}, 32'h1);
    wr(IDX_FRAME, 8'hD5);
    repeat (2) @(posedge ref_clk);
    cmp(32'(n_send), 32'h1);
    cmp({29'h0, modem}, 32'h6);
    cmp({26'h0, rx_align, tx_bits}, 32'h2D);
    rd_chk(IDX_FRAME, 32'h55);
    wr(IDX_FRAME, 8'h00);
    cmp({26'h0, rx_align, tx_bits}, 32'h0);
    exch <= 1'b0;
  endtask : t_frame

  task automatic t_idcopy;
    wr(IDX_CTRL, 8'h20);
    cmp({31'h0, push_ready}, 32'h0);
    repeat (12) @(posedge ref_clk);
    rd_chk(IDX_CTRL, 32'h5);
    rd_chk(IDX_LEVEL, 32'hA);
    for (int i = 1; i <= 10; i++) rd_chk(IDX_DATA, 32'(i));
  endtask : t_idcopy

  task automatic t_core;
    push_valid <= 1'b1;
    push_data <= 8'hA5;
    do @(posedge ref_clk); while (push_ready !== 1'b1);
    push_valid <= 1'b0;
    rd_chk(IDX_DATA, 32'hA5);
    wr(IDX_DATA, 8'h3C);
    cmp({24'h0, pop_data}, 32'h3C);
    pop_req <= 1'b1;
    do @(posedge ref_clk); while (pop_ready !== 1'b1);
    pop_req <= 1'b0;
    rd_chk(IDX_LEVEL, 32'h0);
    cmp({31'h0, pop_ready}, 32'h0);
  endtask : t_core

  initial begin
    repeat (6) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    t_reset();
    t_queue();
    t_fill();
    t_ctrl();
    t_frame();
    t_idcopy();
    t_core();
    complete_run();
  end

  initial begin
    repeat (6000) @(posedge ref_clk);
    n_mismatch++;
    complete_run();
  end
endmodule : test_fifo_and_bit_framing_regs
